// >>> hdl/spmc_core.v
// SPI master/slave controller with command sequencer and double buffers.
`timescale 1ns/1ps
`include "spmc_regs.vh"

module spmc_core (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // Register port
  input  wire [6:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Serial transfer clock pin
  input  wire        serial_transfer_clock_i,
  output wire        serial_transfer_clock_o,
  output wire        serial_transfer_clock_oe,
  // Master-out data pin
  input  wire        mosi_i,
  output wire        mosi_o,
  output wire        mosi_oe,
  // Master-in data pin
  input  wire        miso_i,
  output wire        miso_o,
  output wire        miso_oe,
  // Slave select lines
  input  wire        select_line_0_i,
  output wire [3:0]  slave_select_line_o,
  output wire [3:0]  slave_select_line_oe,
  // Interrupt request levels
  output wire        irq_rx_full,
  output wire        irq_tx_empty,
  output wire        irq_error,
  output wire        irq_idle,
  // Event link pulses
  output reg         ev_rx_full,
  output reg         ev_tx_empty,
  output reg         ev_error,
  output reg         ev_idle,
  output reg         ev_tx_done
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_SETUP = 3'h1;
  localparam [2:0] ST_SHIFT = 3'h2;
  localparam [2:0] ST_FIN   = 3'h3;
  localparam [2:0] ST_NEG   = 3'h4;
  localparam [2:0] ST_NEXT  = 3'h5;

  reg [31:0] ctrl_q;
  reg [7:0]  ctrl2_q;
  reg [31:0] baud_q;
  reg [31:0] seq_q;
  reg [31:0] cmd_q [0:7];
  reg [31:0] txb_q [0:3];
  reg [31:0] txw_q [0:3];
  reg [31:0] rxb_q [0:3];
  reg [31:0] rxw_q [0:3];
  reg        txf_q;
  reg        rxf_q;
  reg        ovr_q;
  reg        mode_fault_flag_q;
  reg        perf_q;
  reg        underrun_flag_q;
  reg [2:0]  st_q;
  reg [10:0] div_q;
  reg [4:0]  dly_q;
  reg [4:0]  nxt_q;
  reg        sck_q;
  reg        so_q;
  reg        par_q;
  reg [5:0]  smp_q;
  reg [5:0]  ob_q;
  reg [1:0]  frm_q;
  reg [2:0]  cur_q;
  reg        sel_act_q;
  reg [1:0]  sel_line_q;
  reg [3:0]  s1_q;
  reg [3:0]  s2_q;
  reg        sck_prev_q;
  reg        err_prev_q;
  reg        rxf_prev_q;
  reg        txf_prev_q;
  reg        idle_prev_q;
  reg [31:0] rd_mux;
  integer    i;

  function [5:0] flen;
    input [3:0] c;
    begin
      if (c <= 4'h8)
        flen = {2'h0, c} + 6'h08;
      else if (c == 4'h9)
        flen = 6'h14;
      else if (c == 4'hA)
        flen = 6'h18;
      else
        flen = 6'h20;
    end
  endfunction

  wire        en      = ctrl_q[`SPMC_CTRL_EN];
  wire        mstr    = ctrl_q[`SPMC_CTRL_MSTR];
  wire        multi   = ctrl_q[`SPMC_CTRL_MULTI];
  wire        three_w = ctrl_q[`SPMC_CTRL_3W];
  wire        tx_only = ctrl_q[`SPMC_CTRL_TXONLY];
  wire        pol     = ctrl_q[`SPMC_CTRL_SELPOL];
  wire        par_en  = ctrl2_q[`SPMC_C2_PAREN];
  wire        par_odd = ctrl2_q[`SPMC_C2_PARODD];
  wire        astop   = ctrl2_q[`SPMC_C2_AUTOSTOP];
  wire [1:0]  frames  = seq_q[`SPMC_SEQ_FRAMES+1:`SPMC_SEQ_FRAMES];
  wire [2:0]  last    = seq_q[`SPMC_SEQ_LAST+2:`SPMC_SEQ_LAST];
  wire [31:0] cmd     = cmd_q[cur_q];
  wire        cpol    = cmd[`SPMC_CMD_CPOL];
  wire        cpha    = cmd[`SPMC_CMD_CPHA];
  wire        lsbf    = cmd[`SPMC_CMD_LSBF];
  wire [5:0]  len     = flen(cmd[`SPMC_CMD_LEN+3:`SPMC_CMD_LEN]);
  wire [5:0]  nbits   = len + {5'h0, par_en};
  // Half period in clocks is the field plus one, so ratios run 2..4096.
  wire [10:0] rate    = cmd[`SPMC_CMD_RATE] ? baud_q[26:16]
                                            : baud_q[10:0];
  wire [2:0]  ncur    = (cur_q == last) ? 3'h0 : cur_q + 3'h1;
  wire [31:0] ncmd    = cmd_q[ncur];

  // Select line 0 and the serial inputs are asynchronous to ref_clk.
  wire sck_s  = s2_q[0];
  wire mosi_s = s2_q[1];
  wire miso_s = s2_q[2];
  wire sel0_s = s2_q[3];
  wire slv_sel = three_w | (sel0_s == pol);

  wire tick    = (div_q == 11'h000);
  wire m_lead  = mstr & tick & (sck_q == cpol);
  wire m_trail = mstr & tick & (sck_q != cpol);
  wire s_edge  = ~mstr & (sck_s ^ sck_prev_q);
  wire s_lead  = s_edge & (sck_prev_q == cpol);
  wire s_trail = s_edge & (sck_prev_q != cpol);
  wire lead    = (st_q == ST_SHIFT) & (m_lead | s_lead);
  wire trail   = (st_q == ST_SHIFT) & (m_trail | s_trail);
  wire smp_e   = cpha ? trail : lead;
  wire shf_e   = cpha ? lead : trail;
  wire [5:0] smp_n = smp_q + {5'h0, smp_e};
  wire fdone   = trail & (smp_n == nbits);
  wire din     = mstr ? miso_s : mosi_s;

  wire [5:0]  rev_s = len - 6'h01 - smp_q;
  wire [5:0]  rev_o = len - 6'h01 - ob_q;
  wire [4:0]  pos_s = lsbf ? smp_q[4:0] : rev_s[4:0];
  wire [4:0]  pos_o = lsbf ? ob_q[4:0] : rev_o[4:0];
  wire [31:0] lmask = ~(32'hFFFFFFFF << len);
  wire [31:0] txcur = txw_q[frm_q];
  wire        txpar = (^(txcur & lmask)) ^ par_odd;
  wire        dout  = (ob_q < len) ? txcur[pos_o] :
                      ((ob_q == len) & par_en) ? txpar : 1'b0;

  wire idle_now = (st_q == ST_IDLE) & ~txf_q;
  wire err_any  = ovr_q | mode_fault_flag_q | perf_q | underrun_flag_q;
  wire rx_keep  = ~tx_only;
  wire hold_rx  = mstr & astop & rx_keep & rxf_q;
  wire dwr      = reg_wr & (reg_addr[6:4] == `SPMC_DATA_PAGE);
  wire drd      = reg_rd & (reg_addr[6:4] == `SPMC_DATA_PAGE);
  wire cwr      = reg_wr & (reg_addr[6:5] == `SPMC_CMD_PAGE);

  assign serial_transfer_clock_o  = sck_q;
  assign serial_transfer_clock_oe = en & mstr;
  assign mosi_o   = so_q;
  assign mosi_oe  = en & mstr;
  assign miso_o   = so_q;
  assign miso_oe  = en & ~mstr & slv_sel;

  assign irq_rx_full  = rxf_q & ctrl_q[`SPMC_CTRL_IE];
  assign irq_tx_empty = ~txf_q & ctrl_q[`SPMC_CTRL_IE+1];
  assign irq_error    = err_any & ctrl_q[`SPMC_CTRL_IE+2];
  assign irq_idle     = idle_now & ctrl_q[`SPMC_CTRL_IE+3];

  // Select pin drivers, one flop pair per line.
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sel
      reg sel_q;
      reg seloe_q;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sel_q <= 1'b1;
          seloe_q <= 1'b0;
        end else begin
          sel_q <= (sel_act_q & (sel_line_q == g)) ? pol : ~pol;
          if (!en || !mstr || three_w)
            seloe_q <= 1'b0;
          else if (!multi)
            seloe_q <= 1'b1;
          else if (g == 0)
            seloe_q <= 1'b0;
          else
            seloe_q <= ctrl_q[`SPMC_CTRL_SELOE+g-1];
        end
      end
      assign slave_select_line_o[g]  = sel_q;
      assign slave_select_line_oe[g] = seloe_q;
    end
  endgenerate

  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `SPMC_OFF_CTRL:   rd_mux = ctrl_q;
      `SPMC_OFF_STATUS: rd_mux = {24'h000000, rxf_q, 1'b0, ~txf_q, underrun_flag_q,
                                  perf_q, mode_fault_flag_q, idle_now, ovr_q};
      `SPMC_OFF_CTRL2:  rd_mux = {24'h000000, ctrl2_q};
      `SPMC_OFF_BAUD:   rd_mux = baud_q;
      `SPMC_OFF_SEQ:    rd_mux = seq_q;
      default: begin
        if (reg_addr[6:5] == `SPMC_CMD_PAGE)
          rd_mux = cmd_q[reg_addr[4:2]];
        else if (reg_addr[6:4] == `SPMC_DATA_PAGE)
          rd_mux = rxb_q[reg_addr[3:2]];
      end
    endcase
  end

  // Registers, flags and the transfer engine share one process so that
  // the order of assignments decides set-over-clear for every flag.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `SPMC_RST_CTRL;
      ctrl2_q <= `SPMC_RST_CTRL2;
      baud_q <= `SPMC_RST_BAUD;
      seq_q <= `SPMC_RST_SEQ;
      for (i = 0; i < 8; i = i + 1)
        cmd_q[i] <= `SPMC_RST_CMD;
      for (i = 0; i < 4; i = i + 1) begin
        txb_q[i] <= 32'h00000000;
        txw_q[i] <= 32'h00000000;
        rxb_q[i] <= 32'h00000000;
        rxw_q[i] <= 32'h00000000;
      end
      {txf_q, rxf_q, ovr_q, mode_fault_flag_q, perf_q, underrun_flag_q} <= 6'h00;
      st_q <= ST_IDLE;
      div_q <= 11'h000;
      dly_q <= 5'h00;
      nxt_q <= 5'h00;
      sck_q <= 1'b0;
      so_q <= 1'b0;
      par_q <= 1'b0;
      smp_q <= 6'h00;
      ob_q <= 6'h00;
      frm_q <= 2'h0;
      cur_q <= 3'h0;
      sel_act_q <= 1'b0;
      sel_line_q <= 2'h0;
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      sck_prev_q <= 1'b0;
      // Idle is true out of reset, so no idle event may follow release.
      {err_prev_q, rxf_prev_q, txf_prev_q, idle_prev_q} <= 4'h1;
      {ev_rx_full, ev_tx_empty, ev_error, ev_idle, ev_tx_done} <= 5'h00;
      reg_rdata <= 32'h00000000;
    end else begin
      s1_q <= {select_line_0_i, miso_i, mosi_i, serial_transfer_clock_i};
      s2_q <= s1_q;
      sck_prev_q <= sck_s;
      so_q <= dout;
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;

      // Events follow the rising edge of each condition.
      err_prev_q <= err_any;
      rxf_prev_q <= rxf_q;
      txf_prev_q <= txf_q;
      idle_prev_q <= idle_now;
      ev_error <= err_any & ~err_prev_q;
      ev_rx_full <= rxf_q & ~rxf_prev_q;
      ev_tx_empty <= ~txf_q & txf_prev_q;
      ev_idle <= idle_now & ~idle_prev_q;
      ev_tx_done <= 1'b0;

      // Software side: configuration and clears.
      if (reg_wr && reg_addr == `SPMC_OFF_CTRL)
        ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == `SPMC_OFF_CTRL2)
        ctrl2_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == `SPMC_OFF_BAUD)
        baud_q <= reg_wdata;
      if (reg_wr && reg_addr == `SPMC_OFF_SEQ)
        seq_q <= reg_wdata;
      if (cwr)
        cmd_q[reg_addr[4:2]] <= reg_wdata;
      // Error flags clear where a zero is written over them.
      if (reg_wr && reg_addr == `SPMC_OFF_STATUS) begin
        if (!reg_wdata[`SPMC_ST_OVR])
          ovr_q <= 1'b0;
        if (!reg_wdata[`SPMC_ST_MODE_FAULT_FLAG])
          mode_fault_flag_q <= 1'b0;
        if (!reg_wdata[`SPMC_ST_PERF])
          perf_q <= 1'b0;
        if (!reg_wdata[`SPMC_ST_UNDERRUN_FLAG])
          underrun_flag_q <= 1'b0;
      end
      // Reading the last word of the round frees the receive buffer.
      if (drd && reg_addr[3:2] == frames)
        rxf_q <= 1'b0;

      // Divider runs only while the master is busy.
      if (st_q == ST_IDLE || !mstr || tick)
        div_q <= rate;
      else
        div_q <= div_q - 11'h001;

      case (st_q)
        ST_IDLE: begin
          sck_q <= cpol;
          smp_q <= 6'h00;
          ob_q <= 6'h00;
          frm_q <= 2'h0;
          par_q <= 1'b0;
          if (!mstr)
            cur_q <= 3'h0;
          if (en && mstr && txf_q && !mode_fault_flag_q) begin
            for (i = 0; i < 4; i = i + 1)
              txw_q[i] <= txb_q[i];
            txf_q <= 1'b0;
            sel_act_q <= 1'b1;
            sel_line_q <= cmd[`SPMC_CMD_SEL+1:`SPMC_CMD_SEL];
            dly_q <= {1'b0, cmd[`SPMC_CMD_CKDLY+2:`SPMC_CMD_CKDLY], 1'b0}
                     + 5'h02;
            st_q <= ST_SETUP;
          end else if (en && !mstr && slv_sel) begin
            if (txf_q) begin
              for (i = 0; i < 4; i = i + 1)
                txw_q[i] <= txb_q[i];
              txf_q <= 1'b0;
            end else begin
              underrun_flag_q <= 1'b1;
              mode_fault_flag_q <= 1'b1;
            end
            st_q <= ST_SHIFT;
          end
        end
        ST_SETUP: begin
          if (tick) begin
            dly_q <= dly_q - 5'h01;
            if (dly_q == 5'h01)
              st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (mstr && tick)
            sck_q <= ~sck_q;
          if (smp_e) begin
            if (smp_q < len) begin
              if (rx_keep)
                rxw_q[frm_q][pos_s] <= din;
              par_q <= par_q ^ din;
            end else if (par_en && ((par_q ^ din) != par_odd)) begin
              perf_q <= 1'b1;
            end
            smp_q <= smp_n;
          end
          if (shf_e)
            ob_q <= smp_q;
          if (fdone) begin
            smp_q <= 6'h00;
            ob_q <= 6'h00;
            par_q <= 1'b0;
            frm_q <= frm_q + 2'h1;
            if (frm_q == frames)
              st_q <= ST_FIN;
          end
          if (!mstr && !slv_sel) begin
            mode_fault_flag_q <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        ST_FIN: begin
          sck_q <= cpol;
          frm_q <= 2'h0;
          if (!hold_rx) begin
            if (rx_keep && rxf_q) begin
              ovr_q <= 1'b1;
            end else if (rx_keep) begin
              for (i = 0; i < 4; i = i + 1)
                rxb_q[i] <= rxw_q[i];
              rxf_q <= 1'b1;
            end
            ev_tx_done <= 1'b1;
            if (!mstr) begin
              st_q <= ST_IDLE;
            end else begin
              cur_q <= ncur;
              nxt_q <= {1'b0, cmd[`SPMC_CMD_NXTDLY+2:`SPMC_CMD_NXTDLY],
                        1'b0} + 5'h02;
              if (cmd[`SPMC_CMD_BURST] && txf_q) begin
                for (i = 0; i < 4; i = i + 1)
                  txw_q[i] <= txb_q[i];
                txf_q <= 1'b0;
                sel_line_q <= ncmd[`SPMC_CMD_SEL+1:`SPMC_CMD_SEL];
                st_q <= ST_SHIFT;
              end else begin
                dly_q <= {1'b0, cmd[`SPMC_CMD_NEGDLY+2:`SPMC_CMD_NEGDLY],
                          1'b0} + 5'h02;
                st_q <= ST_NEG;
              end
            end
          end
        end
        ST_NEG: begin
          if (tick) begin
            dly_q <= dly_q - 5'h01;
            if (dly_q == 5'h01) begin
              sel_act_q <= 1'b0;
              dly_q <= nxt_q;
              st_q <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          if (tick) begin
            dly_q <= dly_q - 5'h01;
            if (dly_q == 5'h01)
              st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase

      // With multi set and three-wire off, another master pulling select line 0 ends this master's transfer.
      if (en && mstr && multi && !three_w && sel0_s == pol) begin
        mode_fault_flag_q <= 1'b1;
        sel_act_q <= 1'b0;
        st_q <= ST_IDLE;
      end
      if (!en) begin
        sel_act_q <= 1'b0;
        st_q <= ST_IDLE;
      end

      // A write to the last word of the round arms the transmit buffer.
      if (dwr) begin
        txb_q[reg_addr[3:2]] <= reg_wdata;
        if (reg_addr[3:2] == frames)
          txf_q <= 1'b1;
      end
    end
  end

endmodule // spmc_core

// >>> hdl/spmc_regs.vh
// Register offsets, field positions and reset values of the SPI controller.
`ifndef SPMC_REGS_VH
`define SPMC_REGS_VH

// Byte offsets on the register port.
`define SPMC_OFF_CTRL     7'h00
`define SPMC_OFF_STATUS   7'h04
`define SPMC_OFF_CTRL2    7'h08
`define SPMC_OFF_BAUD     7'h0C
`define SPMC_OFF_SEQ      7'h10
`define SPMC_CMD_PAGE     2'h1
`define SPMC_DATA_PAGE    3'h4

// Control register fields.
`define SPMC_CTRL_EN      0
`define SPMC_CTRL_MSTR    1
`define SPMC_CTRL_MULTI   2
`define SPMC_CTRL_3W      3
`define SPMC_CTRL_TXONLY  4
`define SPMC_CTRL_SELPOL  5
`define SPMC_CTRL_SELOE   8
`define SPMC_CTRL_IE      12

// Status register fields.
`define SPMC_ST_OVR       0
`define SPMC_ST_IDLE      1
`define SPMC_ST_MODE_FAULT_FLAG      2
`define SPMC_ST_PERF      3
`define SPMC_ST_UNDERRUN_FLAG      4
`define SPMC_ST_TXE       5
`define SPMC_ST_RXF       7

// Second control register fields.
`define SPMC_C2_PAREN     0
`define SPMC_C2_PARODD    1
`define SPMC_C2_AUTOSTOP  4

// Sequence register fields.
`define SPMC_SEQ_LAST     0
`define SPMC_SEQ_FRAMES   4

// Command word fields.
`define SPMC_CMD_SEL      0
`define SPMC_CMD_CPOL     2
`define SPMC_CMD_CPHA     3
`define SPMC_CMD_LEN      4
`define SPMC_CMD_LSBF     8
`define SPMC_CMD_BURST    9
`define SPMC_CMD_CKDLY    10
`define SPMC_CMD_NEGDLY   13
`define SPMC_CMD_NXTDLY   16
`define SPMC_CMD_RATE     20

// Reset values.
`define SPMC_RST_CTRL     32'h00000000
`define SPMC_RST_CTRL2    8'h00
`define SPMC_RST_BAUD     32'h00030003
`define SPMC_RST_SEQ      32'h00000000
`define SPMC_RST_CMD      32'h00000000

`endif

// >>> bench/spmc_peer.sv
// Behavioural SPI slave peer: mode 0, active-low select, eight-bit frames.
`timescale 1ns/1ps
module spmc_peer (
  // Link pins
  input  wire       sck,
  input  wire       sel_n,
  input  wire       mosi,
  output reg        miso,
  // Frame data
  input  wire [7:0] tx_byte,
  output reg  [7:0] rx_byte
);
  reg [7:0] sh_q;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    sh_q = 8'h00;
  end
  // Mode 0 needs the first bit on the line as soon as select asserts.
  always @(negedge sel_n) begin
    sh_q = tx_byte;
    miso = tx_byte[7];
  end
  // A released line shows the inverse of its last level, never a held copy.
  always @(posedge sel_n) miso = ~miso;
  always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck) begin
    if (!sel_n) begin
      sh_q = {sh_q[6:0], 1'b0};
      miso = sh_q[7];
    end
  end
endmodule // spmc_peer

// >>> bench/spmc_core_properties.sv
// Concurrent checks on the SPI controller ports.
`timescale 1ns/1ps
`include "spmc_regs.vh"
module spmc_chk (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst,
  // Register writes
  input wire [6:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  // Link outputs
  input wire        serial_transfer_clock_o,
  input wire        serial_transfer_clock_oe,
  input wire        mosi_oe,
  input wire [3:0]  slave_select_line_o,
  input wire [3:0]  slave_select_line_oe,
  // Interrupt and event
  input wire        irq_error,
  input wire        ev_error,
  input wire        ev_tx_done
);
  reg  [31:0] ctrl_q;
  reg  [1:0]  age_q;
  wire        settled;
  wire        sel_off;
  wire        mstr;
  // Output enables lag a control write, so checks wait until it settles.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 32'h00000000;
      age_q <= 2'h3;
    end else if (reg_wr && reg_addr == `SPMC_OFF_CTRL) begin
      ctrl_q <= reg_wdata;
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end
  assign settled = (age_q == 2'h3);
  assign mstr = ctrl_q[`SPMC_CTRL_EN] & ctrl_q[`SPMC_CTRL_MSTR];
  assign sel_off = slave_select_line_o[0] == ~ctrl_q[`SPMC_CTRL_SELPOL];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_sck_still;
    $stable(serial_transfer_clock_o) [*4];
  endsequence
  sequence s_sel_held_off;
    sel_off [*4];
  endsequence
  a_sck_oe_mode: assert property (settled |->
    serial_transfer_clock_oe == mstr) else $error("sck enable wrong");
  a_mosi_oe_mode: assert property (settled |->
    mosi_oe == mstr) else $error("mosi enable wrong");
  a_single_sel_oe: assert property (settled && mstr &&
    !ctrl_q[`SPMC_CTRL_MULTI] && !ctrl_q[`SPMC_CTRL_3W] |->
    slave_select_line_oe == 4'hF) else $error("single select enable");
  a_multi_sel_oe: assert property (settled && mstr &&
    ctrl_q[`SPMC_CTRL_MULTI] && !ctrl_q[`SPMC_CTRL_3W] |->
    slave_select_line_oe == {ctrl_q[10:8], 1'b0})
    else $error("multi select enable");
  a_slave_sel_oe: assert property (settled &&
    !ctrl_q[`SPMC_CTRL_MSTR] |-> slave_select_line_oe == 4'h0)
    else $error("slave select enable");
  a_lead_delay: assert property (settled && mstr && $fell(sel_off)
    |-> s_sck_still) else $error("clock too soon after select");
  a_lag_delay: assert property (settled && mstr && $rose(sel_off) |->
    $past(serial_transfer_clock_o, 4) == serial_transfer_clock_o)
    else $error("select negated too soon");
  a_next_delay: assert property (settled && mstr && $rose(sel_off)
    |-> s_sel_held_off) else $error("next access too soon");
  a_err_irq_gate: assert property (settled && irq_error
    |-> ctrl_q[14]) else $error("error interrupt not masked");
  a_done_pulse: assert property (ev_tx_done |=> !ev_tx_done)
    else $error("done event too long");
  a_err_event: assert property (settled && $rose(irq_error) |=>
    ev_error) else $error("error event missing");
endmodule // spmc_chk
bind spmc_core spmc_chk spmc_chk_i (
  .ref_clk                  (ref_clk),
  .rst                      (rst),
  .reg_addr                 (reg_addr),
  .reg_wdata                (reg_wdata),
  .reg_wr                   (reg_wr),
  .serial_transfer_clock_o  (serial_transfer_clock_o),
  .serial_transfer_clock_oe (serial_transfer_clock_oe),
  .mosi_oe                  (mosi_oe),
  .slave_select_line_o      (slave_select_line_o),
  .slave_select_line_oe     (slave_select_line_oe),
  .irq_error                (irq_error),
  .ev_error                 (ev_error),
  .ev_tx_done               (ev_tx_done)
);

// >>> bench/spmc_core_tb.sv
// Self-checking bench for the SPI controller with a slave peer model.
`timescale 1ns/1ps
`include "spmc_regs.vh"
module spmc_core_tb;
  reg         ref_clk, rst, reg_wr, reg_rd;
  reg  [6:0]  reg_addr;
  reg  [31:0] reg_wdata;
  wire [31:0] reg_rdata;
  wire        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire [3:0]  sel_o, sel_oe;
  wire        irq_rx_full, irq_tx_empty, irq_error, ev_tx_done, peer_miso;
  reg         sck_drv, mosi_drv, sel_drv;
  reg  [7:0]  peer_tx;
  wire [7:0]  peer_rx;
  integer     fails, total_checks, cycles;
  // Each pin resolves from whoever enables it.
  wire sck_w  = sck_oe ? sck_o : sck_drv;
  wire mosi_w = mosi_oe ? mosi_o : mosi_drv;
  wire miso_w = miso_oe ? miso_o : peer_miso;
  wire sel_w  = sel_oe[0] ? sel_o[0] : sel_drv;

  spmc_core spmc_core_i (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_transfer_clock_i(sck_w),
    .serial_transfer_clock_o(sck_o), .serial_transfer_clock_oe(sck_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .select_line_0_i(sel_w), .slave_select_line_o(sel_o),
    .slave_select_line_oe(sel_oe), .irq_rx_full(irq_rx_full),
    .irq_tx_empty(irq_tx_empty), .irq_error(irq_error), .irq_idle(),
    .ev_rx_full(), .ev_tx_empty(), .ev_error(), .ev_idle(),
    .ev_tx_done(ev_tx_done));
  spmc_peer spmc_peer_i (.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w),
    .miso(peer_miso), .tx_byte(peer_tx), .rx_byte(peer_rx));

  always #10 ref_clk = ~ref_clk;

  task end_sim;
    begin
      $display("Checks made %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // A hung transfer must still reach the verdict.
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      end_sim;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [6:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [6:0] a, output [31:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  task wait_done;
    integer n;
    begin
      n = 0;
      while (ev_tx_done !== 1'b1 && n < 3000) begin
        @(posedge ref_clk);
        #1 n = n + 1;
      end
      chk(n < 3000, 1'b1);
    end
  endtask
  task t_reset;
    reg [31:0] d;
    begin
      rd(`SPMC_OFF_CTRL, d);
      chk(d, `SPMC_RST_CTRL);
      rd(`SPMC_OFF_BAUD, d);
      chk(d, `SPMC_RST_BAUD);
      rd(`SPMC_OFF_CTRL2, d);
      chk(d[7:0], `SPMC_RST_CTRL2);
      rd(`SPMC_OFF_STATUS, d);
      chk({d[7], d[5], d[4], d[2]}, 4'h4);
      rd(7'h7C, d);
      chk(d, 32'h00000000);
      wr(`SPMC_OFF_CTRL2, 32'h00000011);
      rd(`SPMC_OFF_CTRL2, d);
      chk(d[7:0], 8'h11);
      wr(`SPMC_OFF_CTRL2, 32'h00000000);
      wr(`SPMC_OFF_STATUS, 32'h000000FF);
      rd(`SPMC_OFF_STATUS, d);
      chk({d[4:2], d[0]}, 4'h0);
      wr(`SPMC_OFF_CTRL, 32'h00000507);
      repeat (4) @(posedge ref_clk);
      chk(sel_oe, 4'hA);
    end
  endtask
  task t_master(input lsb);
    reg [31:0] d;
    begin
      peer_tx = 8'h36;
      wr(`SPMC_OFF_CTRL, 32'h00003003);
      wr(`SPMC_OFF_SEQ, 32'h00000000);
      wr(7'h20, {23'h0, lsb, 8'h00});
      wr(7'h40, 32'h000000C1);
      wait_done;
      chk(sel_oe, 4'hF);
      chk(irq_tx_empty, 1'b1);
      chk(peer_rx, lsb ? 8'h83 : 8'hC1);
      rd(`SPMC_OFF_STATUS, d);
      chk(d[7], 1'b1);
      chk(irq_rx_full, 1'b1);
      rd(7'h40, d);
      chk(d[7:0], lsb ? 8'h6C : 8'h36);
      rd(`SPMC_OFF_STATUS, d);
      chk(d[7], 1'b0);
      chk(irq_rx_full, 1'b0);
      repeat (40) @(posedge ref_clk);
    end
  endtask
  task t_modefault;
    reg [31:0] d;
    begin
      wr(`SPMC_OFF_CTRL, 32'h00004001);
      repeat (4) @(posedge ref_clk);
      chk(sel_oe, 4'h0);
      sel_drv <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk(miso_oe, 1'b1);
      // Halves of four clocks keep the link above the slave minimum.
      repeat (4) begin
        repeat (4) @(posedge ref_clk);
        sck_drv <= ~sck_drv;
      end
      repeat (4) @(posedge ref_clk);
      sel_drv <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rd(`SPMC_OFF_STATUS, d);
      chk(d[2], 1'b1);
      chk(d[4], 1'b1);
      chk(irq_error, 1'b1);
      wr(`SPMC_OFF_STATUS, 32'h00000000);
      rd(`SPMC_OFF_STATUS, d);
      chk({d[4], d[2]}, 2'h0);
    end
  endtask
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 32'h00000000;
    sck_drv = 1'b0;
    mosi_drv = 1'b0;
    sel_drv = 1'b1;
    peer_tx = 8'h00;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_master(1'b0);
    t_master(1'b1);
    t_modefault;
    end_sim;
  end
endmodule // spmc_core_tb
